/* gdfs_map.svh */
// gate driver fault supervisor: register map, field positions and timing figures
`ifndef GDFS_MAP_SVH
`define GDFS_MAP_SVH

`define GDFS_CLK_NS       100
`define GDFS_CYC_UP(ns)   (((ns) + `GDFS_CLK_NS - 1) / `GDFS_CLK_NS)

// overcurrent filter choices, selected by fsel
`define GDFS_OCF0_NS      1000
`define GDFS_OCF1_NS      2000
`define GDFS_OCF2_NS      4000
`define GDFS_OCF3_NS      8000
`define GDFS_OCF_HW_NS    4000
`define GDFS_GATE_WIN_NS  4000
`define GDFS_WAKE_RST_NS  20000
`define GDFS_RETRY_NS     4000000

`define GDFS_A_STATUS     12'h000
`define GDFS_A_CTRL       12'h004
`define GDFS_A_CMD        12'h008
`define GDFS_A_STATE      12'h00C

`define GDFS_CTRL_RST     32'h00000000
`define GDFS_C_RESP       1:0
`define GDFS_C_FILT       3:2
`define GDFS_C_PUMP_OFF   4
`define GDFS_C_GATE_OFF   5
`define GDFS_C_MODE       10:8
`define GDFS_C_PHASE_FET  14:12
`define GDFS_C_DROP_OFF   18:16
`define GDFS_C_SHUNT_OFF  22:20
`define GDFS_CMD_CLR      0

`define GDFS_S_GLOBAL     0
`define GDFS_S_SUPPLY     1
`define GDFS_S_PUMP       2
`define GDFS_S_DROP       3
`define GDFS_S_SHUNT      4
`define GDFS_S_GATE       5
`define GDFS_S_DROP_FET   13:8
`define GDFS_S_SHUNT_SNS  18:16
`define GDFS_S_GATE_SRC   29:24

`define GDFS_T_GATES      5:0
`define GDFS_T_PUMP       8
`define GDFS_T_FAULT_N    9
`define GDFS_T_RETRY      10

`endif

/* gdfs_pkg.sv */
// gate driver fault supervisor: shared types
package gdfs_pkg;
   typedef enum logic [1:0] {
      RESP_LATCH  = 2'b00,
      RESP_RETRY  = 2'b01,
      RESP_REPORT = 2'b10,
      RESP_OFF    = 2'b11
   } gdfs_resp_e;

   typedef enum logic [2:0] {
      MODE_6X     = 3'b000,
      MODE_3X     = 3'b001,
      MODE_1X     = 3'b010,
      MODE_BRIDGE = 3'b011,
      MODE_FET4   = 3'b100,
      MODE_FET5   = 3'b101,
      MODE_FET6   = 3'b110,
      MODE_FET    = 3'b111
   } gdfs_mode_e;

   typedef enum logic {
      RT_IDLE = 1'b0,
      RT_WAIT = 1'b1
   } gdfs_retry_e;
endpackage

/* gdfs_det_if.sv */
// detector channel: trip level and filter length in, filtered hit out
`timescale 1ns/1ps
interface gdfs_det_if #(parameter int CW = 12);
   logic          trip;
   logic [CW-1:0] limit;
   logic          hit;
   modport mon  (input trip, input limit, output hit);
   modport user (output trip, output limit, input hit);
endinterface

/* gdfs_sync.sv */
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module gdfs_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

/* gdfs_deglitch.sv */
// deglitch filter: hit rises once trip has held for limit+1 cycles
`timescale 1ns/1ps
module gdfs_deglitch #(
   parameter int CW = 12
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   gdfs_det_if.mon   det
);
   logic [CW-1:0] cnt_q;
   logic          hit_q;

   assign det.hit = hit_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         hit_q <= 1'b0;
      end else if (ce) begin
         if (!det.trip) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
         end else if (cnt_q >= det.limit) begin
            hit_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule

/* gdfs_top.sv */
// gate driver fault supervisor: detection, flags, shutdown, retry and APB registers
//
// Behaviour
// - supply undervoltage: gates off, pump off, fault pin low, flags latched
// - gates and fault pin recover when supply returns; flag held until clear
// - pump undervoltage (check on): gates off, fault pin low, flags held
// - pump check off: gates keep running, pump flag still latched until clear
// - drain-source trip on enabled FET counts after filter; response per selector
// - pin variant: 4 us filter, latched response; rail strap disables drop check
// - latched mode: all gates off until condition gone and clear given
// - retry mode: gates off, then restart and flags clear after retry wait
// - report mode: fault pin and flags only, gates keep running
// - disabled mode: drop check ignored, per-bridge drop disables locked
// - shunt trip filtered the same way and handled by same four responses
// - pin variant: shunt filter fixed and response latched
// - shunt flags: retry latches per-sense bits; disabled mode locks shunt disables
// - gate that fails to slew within window is a gate fault; window blanks
// - gate fault (check on): affected gates off, fault pin low, flags held
// - gate check off: gates run, source flag latched until clear
// - 6x, 3x, 1x modes: any gate fault turns all gates off
// - half-bridge mode: gate fault turns off both gates of that bridge
// - independent FET modes 100b to 111b: only the faulty gate off
// - per-phase setting picks bridge or single-gate shutdown for that phase
// - global flag is the OR of every individual flag
`timescale 1ns/1ps
`include "gdfs_map.svh"
module gdfs_top #(
   parameter bit HW_VARIANT   = 1'b0,
   parameter int RETRY_CYCLES = `GDFS_CYC_UP(`GDFS_RETRY_NS)
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        supply_low_pin,
   input  wire logic        pump_low_pin,
   input  wire logic [5:0]  drop_trip_pin,
   input  wire logic [2:0]  shunt_trip_pin,
   input  wire logic [5:0]  gate_sense_pin,
   input  wire logic        enable_pin,
   input  wire logic        drop_level_at_rail,
   input  wire logic [2:0]  mode_pin,
   input  wire logic [5:0]  gate_cmd,
   output logic      [5:0]  gate_out,
   output logic             pump_on,
   output logic             fault_out_n
);
   localparam int CW  = 12;
   localparam int RW  = $clog2(RETRY_CYCLES + 1);
   localparam int NDT = 15;
   localparam logic [CW-1:0] OCF0 = CW'(`GDFS_CYC_UP(`GDFS_OCF0_NS));
   localparam logic [CW-1:0] OCF1 = CW'(`GDFS_CYC_UP(`GDFS_OCF1_NS));
   localparam logic [CW-1:0] OCF2 = CW'(`GDFS_CYC_UP(`GDFS_OCF2_NS));
   localparam logic [CW-1:0] OCF3 = CW'(`GDFS_CYC_UP(`GDFS_OCF3_NS));
   localparam logic [CW-1:0] OCFH = CW'(`GDFS_CYC_UP(`GDFS_OCF_HW_NS));
   localparam logic [CW-1:0] GWIN = CW'(`GDFS_CYC_UP(`GDFS_GATE_WIN_NS));
   localparam logic [CW-1:0] WAKE = CW'(`GDFS_CYC_UP(`GDFS_WAKE_RST_NS));
   localparam logic [RW-1:0] RLAST = RW'(RETRY_CYCLES - 1);

   // shutdown scope of gate faults according to the drive mode
   function automatic logic [5:0] gate_scope(input logic [5:0] flt,
                                             input logic [2:0] mode,
                                             input logic [2:0] phase_fet);
      logic [5:0] m;
      m = '0;
      if (mode[2]) begin
         m = flt;
      end else if (mode == gdfs_pkg::MODE_BRIDGE) begin
         for (int p = 0; p < 3; p++) begin
            if (phase_fet[p]) begin
               m[2*p +: 2] = flt[2*p +: 2];
            end else begin
               m[2*p +: 2] = {2{|flt[2*p +: 2]}};
            end
         end
      end else begin
         m = {6{|flt}};
      end
      return m;
   endfunction

   // pins pass two flops before any logic sees them
   logic [21:0] pins_s;
   logic        sup_uv;
   logic        pump_uv;
   logic [5:0]  drop_s;
   logic [2:0]  shunt_s;
   logic [5:0]  gsense_s;
   logic        en_s;
   logic        rail_s;
   logic [2:0]  mode_s;

   gdfs_sync #(.W(22)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       ({supply_low_pin, pump_low_pin, drop_trip_pin, shunt_trip_pin,
                 gate_sense_pin, enable_pin, drop_level_at_rail, mode_pin}),
      .q       (pins_s)
   );
   assign {sup_uv, pump_uv, drop_s, shunt_s, gsense_s, en_s, rail_s, mode_s} = pins_s;

   // registers
   logic [31:0]  ctrl_q;
   logic [5:0]   gate_out_q;
   logic         pump_on_q;
   logic         fault_n_q;
   logic [31:0]  prdata_q;
   logic         pready_q;
   logic         pslverr_q;
   logic         supply_flag_q;
   logic         pump_flag_q;
   logic [5:0]   drop_flag_q;
   logic         shunt_flag_q;
   logic [2:0]   shunt_sns_q;
   logic         gate_stuck_q;
   logic [5:0]   gate_src_q;
   logic [5:0]   gate_blk_q;
   logic         ocp_shut_q;
   logic [NDT-1:0] hit_q;
   gdfs_pkg::gdfs_retry_e rt_st_q;
   logic [RW-1:0] rt_cnt_q;
   logic [CW-1:0] wk_cnt_q;
   logic          en_q;

   // effective configuration; the pin variant pins several fields
   wire gdfs_pkg::gdfs_resp_e resp = HW_VARIANT ? gdfs_pkg::RESP_LATCH
                                     : gdfs_pkg::gdfs_resp_e'(ctrl_q[`GDFS_C_RESP]);
   wire [2:0] mode      = HW_VARIANT ? mode_s : ctrl_q[`GDFS_C_MODE];
   wire       pump_off  = !HW_VARIANT && ctrl_q[`GDFS_C_PUMP_OFF];
   wire       gchk_off  = !HW_VARIANT && ctrl_q[`GDFS_C_GATE_OFF];
   wire [2:0] drop_off  = ctrl_q[`GDFS_C_DROP_OFF];
   wire [2:0] shunt_off = ctrl_q[`GDFS_C_SHUNT_OFF];
   wire       ocp_on    = (resp != gdfs_pkg::RESP_OFF);
   wire       drop_on   = ocp_on && !(HW_VARIANT && rail_s);
   wire [1:0] fsel      = ctrl_q[`GDFS_C_FILT];
   wire [CW-1:0] ocf_lim = HW_VARIANT ? OCFH :
                           (fsel == 2'b00) ? OCF0 :
                           (fsel == 2'b01) ? OCF1 :
                           (fsel == 2'b10) ? OCF2 : OCF3;

   // detector channels: 0..5 drop, 6..8 shunt, 9..14 gate slew
   gdfs_det_if #(.CW(CW)) det [NDT] ();
   logic [NDT-1:0] hit;

   for (genvar i = 0; i < NDT; i++) begin : g_det
      if (i < 6) begin : g_drop
         assign det[i].trip  = drop_s[i] && gate_out_q[i] && !drop_off[i/2] && drop_on;
         assign det[i].limit = ocf_lim;
      end else if (i < 9) begin : g_shunt
         assign det[i].trip  = shunt_s[i-6] && !shunt_off[i-6] && ocp_on;
         assign det[i].limit = ocf_lim;
      end else begin : g_gate
         // mismatch lasting past the window; slewing inside it is blanked
         assign det[i].trip  = (gsense_s[i-9] != gate_out_q[i-9]);
         assign det[i].limit = GWIN;
      end
      assign hit[i] = det[i].hit;
      gdfs_deglitch #(.CW(CW)) u_dg (
         .pclk    (pclk),
         .presetn (presetn),
         .ce      (ce),
         .det     (det[i])
      );
   end

   wire [5:0] drop_hit  = hit[5:0];
   wire [2:0] shunt_hit = hit[8:6];
   wire [5:0] gate_hit  = hit[14:9];
   wire [NDT-1:0] rise  = hit & ~hit_q;
   wire       ocp_ev    = |rise[8:0];
   wire       ocp_cond  = |hit[8:0];
   wire [5:0] gate_ev   = rise[14:9];

   // APB: one wait state, answer registered in the first access cycle
   wire       acc_first = psel && penable && !pready_q;
   wire       acc_done  = psel && penable && pready_q;
   wire       a_status  = (paddr == `GDFS_A_STATUS);
   wire       a_ctrl    = (paddr == `GDFS_A_CTRL);
   wire       a_cmd     = (paddr == `GDFS_A_CMD);
   wire       a_state   = (paddr == `GDFS_A_STATE);
   wire       a_hit     = a_status || a_ctrl || a_cmd || a_state;
   wire       wr_ctrl   = acc_done && pwrite && a_ctrl && !HW_VARIANT;
   wire       cmd_clr   = acc_done && pwrite && a_cmd && pwdata[`GDFS_CMD_CLR];

   // enable pin held low long enough, then released, acts as a clear
   wire       wake_clr  = en_s && !en_q && (wk_cnt_q >= WAKE);
   wire       clr       = cmd_clr || wake_clr;

   // retry timer
   wire       rt_busy   = (rt_st_q == gdfs_pkg::RT_WAIT);
   wire       rt_done   = rt_busy && (rt_cnt_q == RLAST);

   wire       glob = supply_flag_q || pump_flag_q || (|drop_flag_q) || shunt_flag_q
                     || (|shunt_sns_q) || gate_stuck_q || (|gate_src_q);

   wire       pump_stop = pump_uv && !pump_off;
   wire       all_off   = sup_uv || pump_stop || ocp_shut_q || rt_busy;
   wire [5:0] gate_d    = all_off ? 6'h00 : (gate_cmd & ~gate_blk_q);
   // supply and pump flags alone do not hold the pin once the condition is gone
   wire       pending   = sup_uv || pump_stop || (|drop_flag_q) || shunt_flag_q
                          || gate_stuck_q || ocp_shut_q || rt_busy;

   // a write in disabled mode leaves the per-bridge disables untouched
   wire       lock_off  = (resp == gdfs_pkg::RESP_OFF);
   wire [31:0] ctrl_w;
   assign ctrl_w[`GDFS_C_RESP]      = pwdata[`GDFS_C_RESP];
   assign ctrl_w[`GDFS_C_FILT]      = pwdata[`GDFS_C_FILT];
   assign ctrl_w[`GDFS_C_PUMP_OFF]  = pwdata[`GDFS_C_PUMP_OFF];
   assign ctrl_w[`GDFS_C_GATE_OFF]  = pwdata[`GDFS_C_GATE_OFF];
   assign ctrl_w[7:6]               = 2'h0;
   assign ctrl_w[`GDFS_C_MODE]      = pwdata[`GDFS_C_MODE];
   assign ctrl_w[11]                = 1'b0;
   assign ctrl_w[`GDFS_C_PHASE_FET] = pwdata[`GDFS_C_PHASE_FET];
   assign ctrl_w[15]                = 1'b0;
   assign ctrl_w[`GDFS_C_DROP_OFF]  = lock_off ? drop_off : pwdata[`GDFS_C_DROP_OFF];
   assign ctrl_w[19]                = 1'b0;
   assign ctrl_w[`GDFS_C_SHUNT_OFF] = lock_off ? shunt_off : pwdata[`GDFS_C_SHUNT_OFF];
   assign ctrl_w[31:23]             = 9'h000;

   wire [31:0] status_v;
   assign status_v[`GDFS_S_GLOBAL]   = glob;
   assign status_v[`GDFS_S_SUPPLY]   = supply_flag_q;
   assign status_v[`GDFS_S_PUMP]     = pump_flag_q;
   assign status_v[`GDFS_S_DROP]     = |drop_flag_q;
   assign status_v[`GDFS_S_SHUNT]    = shunt_flag_q;
   assign status_v[`GDFS_S_GATE]     = gate_stuck_q;
   assign status_v[7:6]              = 2'h0;
   assign status_v[`GDFS_S_DROP_FET] = drop_flag_q;
   assign status_v[15:14]            = 2'h0;
   assign status_v[`GDFS_S_SHUNT_SNS]= shunt_sns_q;
   assign status_v[23:19]            = 5'h00;
   assign status_v[`GDFS_S_GATE_SRC] = gate_src_q;
   assign status_v[31:30]            = 2'h0;

   wire [31:0] state_v = {21'h000000, rt_busy, fault_n_q, pump_on_q, 2'h0, gate_out_q};

   wire [31:0] rd_v = a_status ? status_v :
                      a_ctrl   ? ctrl_q   :
                      a_state  ? state_v  : 32'h00000000;

   wire [5:0] blk_set = gchk_off ? 6'h00 : gate_scope(gate_ev, mode, ctrl_q[`GDFS_C_PHASE_FET]);

   // bus side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q    <= `GDFS_CTRL_RST;
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q  <= acc_first;
         pslverr_q <= acc_first && !a_hit;
         prdata_q  <= (acc_first && !pwrite) ? rd_v : 32'h00000000;
         if (wr_ctrl) begin
            ctrl_q <= ctrl_w;
         end
      end
   end

   // outputs and enable-pin pulse timing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_out_q <= 6'h00;
         pump_on_q  <= 1'b0;
         fault_n_q  <= 1'b1;
         hit_q      <= '0;
         en_q       <= 1'b0;
         wk_cnt_q   <= '0;
      end else if (ce) begin
         gate_out_q <= gate_d;
         pump_on_q  <= !sup_uv;
         fault_n_q  <= !pending;
         hit_q      <= hit;
         en_q       <= en_s;
         if (en_s) begin
            wk_cnt_q <= '0;
         end else if (wk_cnt_q < WAKE) begin
            wk_cnt_q <= wk_cnt_q + 1'b1;
         end
      end
   end

   // sticky flags: a set in the same cycle as a clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_flag_q <= 1'b0;
         pump_flag_q   <= 1'b0;
         gate_stuck_q  <= 1'b0;
         gate_src_q    <= 6'h00;
         gate_blk_q    <= 6'h00;
      end else if (ce) begin
         supply_flag_q <= sup_uv || (supply_flag_q && !clr);
         pump_flag_q   <= pump_uv || (pump_flag_q && !clr);
         gate_stuck_q  <= (|gate_ev && !gchk_off) || (gate_stuck_q && !clr);
         gate_src_q    <= gate_ev | (clr ? 6'h00 : gate_src_q);
         gate_blk_q    <= blk_set | (clr ? 6'h00 : gate_blk_q);
      end
   end

   // overcurrent flags and shutdown hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drop_flag_q  <= 6'h00;
         shunt_flag_q <= 1'b0;
         shunt_sns_q  <= 3'h0;
         ocp_shut_q   <= 1'b0;
      end else if (ce) begin
         drop_flag_q  <= drop_hit | ((clr || rt_done) ? 6'h00 : drop_flag_q);
         shunt_flag_q <= (|shunt_hit) || (shunt_flag_q && !(clr || rt_done));
         shunt_sns_q  <= ((resp == gdfs_pkg::RESP_RETRY) ? shunt_hit : 3'h0)
                         | ((clr || rt_done) ? 3'h0 : shunt_sns_q);
         if (ocp_ev && resp == gdfs_pkg::RESP_LATCH) begin
            ocp_shut_q <= 1'b1;
         end else if (clr && !ocp_cond) begin
            ocp_shut_q <= 1'b0;
         end
      end
   end

   // retry timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rt_st_q  <= gdfs_pkg::RT_IDLE;
         rt_cnt_q <= '0;
      end else if (ce) begin
         case (rt_st_q)
            gdfs_pkg::RT_IDLE: begin
               rt_cnt_q <= '0;
               if (ocp_ev && resp == gdfs_pkg::RESP_RETRY) begin
                  rt_st_q <= gdfs_pkg::RT_WAIT;
               end
            end
            gdfs_pkg::RT_WAIT: begin
               if (rt_done) begin
                  rt_st_q  <= gdfs_pkg::RT_IDLE;
                  rt_cnt_q <= '0;
               end else begin
                  rt_cnt_q <= rt_cnt_q + 1'b1;
               end
            end
            default: begin
               rt_st_q  <= gdfs_pkg::RT_IDLE;
               rt_cnt_q <= '0;
            end
         endcase
      end
   end

   assign gate_out    = gate_out_q;
   assign pump_on     = pump_on_q;
   assign fault_out_n = fault_n_q;
   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
endmodule

/* gdfs_top_properties.sv */
// assertion checker bound to the fault supervisor top ports
`timescale 1ns/1ps
module gdfs_top_properties #(
   parameter int RETRY_CYCLES = 40000
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        supply_low_pin,
   input wire logic [5:0]  gate_cmd,
   input wire logic [5:0]  gate_out,
   input wire logic        pump_on,
   input wire logic        fault_out_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   supply_off_a: assert property (supply_low_pin [*4] |->
      gate_out == 6'h00 && !pump_on && !fault_out_n) else $error("supply low not shut down");
   pump_up_a: assert property (!supply_low_pin [*4] |-> pump_on)
      else $error("pump off with supply good");
   gate_mask_a: assert property ((gate_out & ~$past(gate_cmd)) == 6'h00)
      else $error("gate driven without command");
   // the first sample after reset release still shows the reset-time gates
   healthy_pass_a: assert property ((fault_out_n && presetn) [*3] |->
      $past(gate_out) == $past(gate_cmd, 2)) else $error("gates masked with fault pin high");
   apb_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
      else $error("access not answered after one wait state");
   ready_req_a: assert property (pready |-> psel && penable ##1 !pready)
      else $error("ready outside a single access cycle");
   err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response malformed");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");

   cover property (supply_low_pin [*4]);
   cover property (pready && pslverr);
   cover property (!fault_out_n && gate_out == 6'h3F);
endmodule

bind gdfs_top gdfs_top_properties #(.RETRY_CYCLES(RETRY_CYCLES)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .supply_low_pin(supply_low_pin),
   .gate_cmd(gate_cmd), .gate_out(gate_out), .pump_on(pump_on), .fault_out_n(fault_out_n));

/* gdfs_ctrl_model.sv */
// controller model: issues enable-pin clear pulses on request
`timescale 1ns/1ps
module gdfs_ctrl_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pulse_req,
   output logic      enable_pin
);
   logic [7:0] cnt_q = 8'h00;
   // a little over the minimum low time, so the clear is never marginal
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_q <= 8'h00;
      else if (pulse_req) cnt_q <= 8'hCD;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
   end
   assign enable_pin = (cnt_q == 8'h00);
endmodule

/* tb.sv */
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
`include "gdfs_map.svh"
module tb;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} gdfs_exp_s;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wake_req = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, pump_on, fault_out_n, enable_pin;
   logic        supply_low_pin = 1'b0, pump_low_pin = 1'b0;
   logic [5:0]  drop_trip_pin = 6'h00, stuck = 6'h00, gate_cmd = 6'h3F, gate_out, gx;
   logic [2:0]  shunt_trip_pin = 3'h0;
   integer      errors = 0, checks = 0, seed = 28, k;
   gdfs_exp_s   q[$];
   gdfs_exp_s   x;

   always #50 pclk = ~pclk;

   gdfs_top #(.RETRY_CYCLES(50)) uut (
      .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .supply_low_pin(supply_low_pin), .pump_low_pin(pump_low_pin),
      .drop_trip_pin(drop_trip_pin), .shunt_trip_pin(shunt_trip_pin),
      .gate_sense_pin(gate_out ^ stuck), .enable_pin(enable_pin), .drop_level_at_rail(1'b0),
      .mode_pin(3'h0), .gate_cmd(gate_cmd), .gate_out(gate_out), .pump_on(pump_on),
      .fault_out_n(fault_out_n));
   gdfs_ctrl_model ctl (.pclk(pclk), .presetn(presetn), .pulse_req(wake_req),
      .enable_pin(enable_pin));

   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         x = q.pop_front();
         checks++;
         if ((prdata & x.m) !== x.d || pslverr !== x.e) begin
            errors++;
            $display("mismatch at %0t: got %h/%h expected %h/%h", $time, prdata, pslverr,
               x.d, x.e);
         end
      end
   end

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m = 32'hFFFFFFFF, input logic e = 1'b0);
      q.push_back('{w ? 32'h0 : d, w ? 32'h0 : m, e});
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task clr;
      xfer(1'b1, `GDFS_A_CMD, 32'h1);
   endtask

   task complete_run;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // a few thousand cycles expected; generous margin
   initial begin
      cyc(20000);
      errors++;
      complete_run;
   end

   initial begin
      cyc(8);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, `GDFS_A_CTRL, `GDFS_CTRL_RST);
      xfer(1'b0, 12'h010, 32'h0, 32'hFFFFFFFF, 1'b1);
      xfer(1'b1, 12'h010, 32'h5, 32'h0, 1'b1);
      r = $random(seed) & 32'h0077773C;
      xfer(1'b1, `GDFS_A_CTRL, r);
      xfer(1'b0, `GDFS_A_CTRL, r);
      xfer(1'b1, `GDFS_A_CTRL, 32'h3);
      xfer(1'b1, `GDFS_A_CTRL, 32'h00770003);
      xfer(1'b0, `GDFS_A_CTRL, 32'h3);
      xfer(1'b1, `GDFS_A_CTRL, 32'h0);
      repeat (30) begin
         @(posedge pclk);
         gate_cmd <= 6'($random(seed));
      end
      @(posedge pclk);
      gate_cmd <= 6'h3F;
      cyc(6);
      for (k = 0; k < 3; k++) begin
         xfer(1'b1, `GDFS_A_CTRL, k == 2 ? 32'h10 : 32'h0);
         {pump_low_pin, supply_low_pin} <= k == 0 ? 2'b01 : 2'b10;
         cyc(6);
         r = k == 0 ? 32'h0 : k == 1 ? 32'h100 : 32'h33F;
         xfer(1'b0, `GDFS_A_STATE, r, 32'h3FF);
         xfer(1'b0, `GDFS_A_STATUS, k == 0 ? 32'h3 : 32'h5);
         {pump_low_pin, supply_low_pin} <= 2'b00;
         cyc(6);
         xfer(1'b0, `GDFS_A_STATE, 32'h33F, 32'h3FF);
         xfer(1'b0, `GDFS_A_STATUS, k == 0 ? 32'h3 : 32'h5);
         if (k == 2) begin
            wake_req <= 1'b1;
            @(posedge pclk);
            wake_req <= 1'b0;
            cyc(215);
         end
         else clr;
         xfer(1'b0, `GDFS_A_STATUS, 32'h0);
      end
      drop_trip_pin <= 6'h04;
      cyc(9);
      drop_trip_pin <= 6'h00;
      cyc(6);
      xfer(1'b0, `GDFS_A_STATUS, 32'h0);
      // each filter choice: a trip of exactly its length is ignored, one cycle more latches
      for (k = 0; k < 8; k++) begin
         xfer(1'b1, `GDFS_A_CTRL, (k >> 1) << 2);
         r = k < 2 ? `GDFS_OCF0_NS : k < 4 ? `GDFS_OCF1_NS
             : k < 6 ? `GDFS_OCF2_NS : `GDFS_OCF3_NS;
         drop_trip_pin <= 6'h04;
         cyc((k & 1) + `GDFS_CYC_UP(r));
         drop_trip_pin <= 6'h00;
         cyc(6);
         xfer(1'b0, `GDFS_A_STATUS, (k & 1) ? 32'h409 : 32'h0);
         if (k & 1) clr;
      end
      for (k = 0; k < 8; k++) begin
         r = k % 4;
         xfer(1'b1, `GDFS_A_CTRL, r);
         if (k < 4) drop_trip_pin <= 6'h04;
         else shunt_trip_pin <= 3'h1;
         cyc(16);
         r = (k % 4 == 3) ? 32'h0 : k < 4 ? 32'h409 : (k % 4 == 1) ? 32'h10011 : 32'h11;
         xfer(1'b0, `GDFS_A_STATUS, r);
         r = k % 4 == 0 ? 32'h100 : k % 4 == 1 ? 32'h500 : k % 4 == 2 ? 32'h13F : 32'h33F;
         xfer(1'b0, `GDFS_A_STATE, r);
         drop_trip_pin <= 6'h00;
         shunt_trip_pin <= 3'h0;
         cyc(60);
         xfer(1'b0, `GDFS_A_STATE, k % 4 == 1 ? 32'h33F : r);
         clr;
         xfer(1'b0, `GDFS_A_STATE, 32'h33F);
         xfer(1'b0, `GDFS_A_STATUS, 32'h0);
      end
      for (k = 0; k < 10; k++) begin
         r = k < 8 ? k << 8 : k == 8 ? 32'h1300 : 32'h20;
         xfer(1'b1, `GDFS_A_CTRL, r);
         stuck <= 6'h01;
         cyc(50);
         gx = k == 9 ? 6'h3F : k < 3 ? 6'h00 : k == 3 ? 6'h3C : 6'h3E;
         r = {22'h0, k != 9 ? 2'b01 : 2'b11, 2'b00, gx};
         xfer(1'b0, `GDFS_A_STATE, r);
         xfer(1'b0, `GDFS_A_STATUS, k == 9 ? 32'h1000001 : 32'h1000021);
         stuck <= 6'h00;
         cyc(4);
         xfer(1'b0, `GDFS_A_STATE, r);
         clr;
         xfer(1'b0, `GDFS_A_STATE, 32'h33F);
      end
      complete_run;
   end
endmodule
